// >>> fzas_map.svh
/*
 Constants for the fence zone alarm supervision block: default settings,
 timing figures and derived tick counts.
 Assumes a 25 MHz system clock; included by bare name.
*/
`ifndef FZAS_MAP_SVH
`define FZAS_MAP_SVH
`define FZAS_CLK_HZ 25000000
`define FZAS_TICK_MS 100
`define FZAS_TICK_CYCLES ((`FZAS_CLK_HZ / 1000) * `FZAS_TICK_MS)
`define FZAS_GAIN_DEF 2'h1
`define FZAS_EVT_COUNT_DEF 8'h04
`define FZAS_EVT_THRESH_DEF 12'h032
`define FZAS_WIN_S_DEF 30
`define FZAS_WIN_TICKS_DEF 16'h012C
`define FZAS_EXT_PCT_DEF 20
`define FZAS_EXT_TICKS_DEF 16'h003C
`define FZAS_DUR_S_DEF 3
`define FZAS_DUR_TICKS_DEF 16'h001E
`define FZAS_SUP_THRESH_DEF 12'h032
`define FZAS_SUP_DUR_S_DEF 5
`define FZAS_SUP_DUR_TICKS_DEF 12'h032
`define FZAS_SUP_DUR_TICKS_MAX 12'h960
`endif

// >>> fzas_pkg.sv
/*
 Types for the fence zone alarm supervision block.
 Assumes fzas_map.svh supplies all numeric constants.
*/
package fzas_pkg;
   // Detection settings shared by all zones
   typedef struct packed {
      logic [7:0] evt_count;
      logic [11:0] evt_thresh;
      logic [15:0] win_ticks;
      logic [15:0] ext_ticks;
      logic [15:0] dur_ticks;
   } fzas_det_cfg_s;
   // Supervision settings
   typedef struct packed {
      logic [11:0] sup_thresh;
      logic [11:0] sup_dur_ticks;
   } fzas_sup_cfg_s;
   typedef enum logic {FZAS_WIN_IDLE, FZAS_WIN_RUN} fzas_win_e;
endpackage : fzas_pkg

// >>> fzas_top.sv
/*
 Per-zone intrusion detection and cable supervision for an optical fence
 sensor processor. Assumes one magnitude sample per zone per mclk arrives
 with sample_valid, synchronous to mclk; settings are static plain ports.
*/
`timescale 1ns/10ps
`include "fzas_map.svh"
module fzas_top #(
   parameter int ZONES = 2,
   parameter int TICK_CYCLES = `FZAS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Samples from the optical front end
   input wire logic sample_valid,
   input wire logic [ZONES*12-1:0] sample_mag,
   // Settings
   input wire logic [ZONES*2-1:0] rx_gain,
   input wire fzas_pkg::fzas_det_cfg_s det_cfg,
   input wire fzas_pkg::fzas_sup_cfg_s sup_cfg,
   // Alarms, levels per zone; tick_100ms is a single shared pulse
   output logic [ZONES-1:0] intrusion_alarm,
   output logic [ZONES-1:0] supervision_alarm,
   output logic tick_100ms
);
   // Tick counter and the clamped supervision limit
   logic [31:0] tick_cnt_reg;
   logic [11:0] sup_dur_lim;

   // Free-running 100 ms tick; counts above 4096 so it is a parameter
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_reg <= 32'h0;
         tick_100ms <= 1'b0;
      end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 32'h0;
         tick_100ms <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
         tick_100ms <= 1'b0;
      end
   end

   // Settings beyond 240 s are held at 240 s
   assign sup_dur_lim = (sup_cfg.sup_dur_ticks > `FZAS_SUP_DUR_TICKS_MAX) ?
      `FZAS_SUP_DUR_TICKS_MAX : sup_cfg.sup_dur_ticks;

   // Gain applied, saturating at the 12-bit full scale
   function automatic logic [11:0] apply_gain(input logic [11:0] mag, input logic [1:0] g);
      logic [13:0] p;
      p = 14'h0;
      case (g)
         2'h2: p = {1'b0, mag, 1'b0};
         2'h3: p = {2'h0, mag} + {1'b0, mag, 1'b0};
         default: p = {2'h0, mag};
      endcase
      apply_gain = (p > 14'h0FFF) ? 12'hFFF : p[11:0];
   endfunction : apply_gain

   genvar z;
   generate
      for (z = 0; z < ZONES; z++) begin : g_zone
         logic [11:0] mag;
         logic above;

         // Window and climb state
         fzas_pkg::fzas_win_e win_reg;
         logic [15:0] left_reg;
         logic [7:0] evt_reg;
         logic [15:0] dur_reg;
         logic above_d_reg;

         // Supervision state
         logic [11:0] max_reg;
         logic [11:0] min_reg;
         logic [11:0] sup_reg;
         logic [11:0] spread;
         logic new_evt;
         logic hit_count;
         logic hit_dur;
         logic hit_any;
         logic [16:0] ext_sum;
         logic empty_period;
         logic [11:0] sup_next;

         assign mag = apply_gain(sample_mag[z*12 +: 12], rx_gain[z*2 +: 2]);
         assign above = sample_valid && (mag > det_cfg.evt_thresh);
         // An event is a rising crossing of the threshold
         assign new_evt = above && !above_d_reg;
         assign hit_count = new_evt && (evt_reg + 8'h1 >= det_cfg.evt_count);
         assign hit_dur = (win_reg == fzas_pkg::FZAS_WIN_RUN) && tick_100ms && above_d_reg
            && (dur_reg + 16'h1 >= det_cfg.dur_ticks);
         assign hit_any = hit_count || hit_dur;
         // Time left after an extension; a tick in the same cycle still counts down
         assign ext_sum = {1'b0, left_reg} + {1'b0, det_cfg.ext_ticks} - {16'h0, tick_100ms};
         assign spread = max_reg - min_reg;
         // A period with no valid sample leaves min above max, read as no spread
         assign empty_period = (min_reg > max_reg);

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               above_d_reg <= 1'b0;
            end else if (sample_valid) begin
               above_d_reg <= above;
            end
         end

         // Intrusion alarm stands until the next tick; a hit on that same tick wins
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               intrusion_alarm[z] <= 1'b0;
            end else if (hit_any) begin
               intrusion_alarm[z] <= 1'b1;
            end else if (tick_100ms) begin
               intrusion_alarm[z] <= 1'b0;
            end
         end

         // Alarm window, event count and climb time
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               win_reg <= fzas_pkg::FZAS_WIN_IDLE;
               left_reg <= 16'h0;
               evt_reg <= 8'h0;
               dur_reg <= 16'h0;
            end else begin
               if (hit_any) begin
                  win_reg <= fzas_pkg::FZAS_WIN_IDLE;
                  left_reg <= 16'h0;
                  evt_reg <= 8'h0;
                  dur_reg <= 16'h0;
               end else begin
                  case (win_reg)
                     fzas_pkg::FZAS_WIN_IDLE: begin
                        if (new_evt) begin
                           win_reg <= fzas_pkg::FZAS_WIN_RUN;
                           left_reg <= det_cfg.win_ticks;
                           evt_reg <= 8'h1;
                        end
                     end
                     fzas_pkg::FZAS_WIN_RUN: begin
                        if (new_evt) begin
                           evt_reg <= evt_reg + 8'h1;
                           // Extension saturates rather than wrapping the timer
                           left_reg <= ext_sum[16] ? 16'hFFFF : ext_sum[15:0];
                        end else if (tick_100ms) begin
                           if (left_reg <= 16'h1) begin
                              win_reg <= fzas_pkg::FZAS_WIN_IDLE;
                              left_reg <= 16'h0;
                              evt_reg <= 8'h0;
                              dur_reg <= 16'h0;
                           end else begin
                              left_reg <= left_reg - 16'h1;
                              if (above_d_reg) begin
                                 dur_reg <= dur_reg + 16'h1;
                              end
                           end
                        end
                     end
                     default: win_reg <= fzas_pkg::FZAS_WIN_IDLE;
                  endcase
               end
            end
         end

         // Per-period max/min capture, restarted on each tick
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               max_reg <= 12'h000;
               min_reg <= 12'hFFF;
            end else if (tick_100ms) begin
               max_reg <= sample_valid ? mag : 12'h000;
               min_reg <= sample_valid ? mag : 12'hFFF;
            end else if (sample_valid) begin
               if (mag > max_reg) max_reg <= mag;
               if (mag < min_reg) min_reg <= mag;
            end
         end

         // Next supervision time for the period that the tick closes
         always_comb begin
            sup_next = sup_reg;
            if (empty_period || spread < sup_cfg.sup_thresh) begin
               // Held at the limit so a later recovery clears the alarm promptly
               if (sup_reg < sup_dur_lim) begin
                  sup_next = sup_reg + 12'h1;
               end
            end else if (spread > sup_cfg.sup_thresh && sup_reg != 12'h0) begin
               sup_next = sup_reg - 12'h1;
            end
         end

         // Supervision time and alarm move only on the tick
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               sup_reg <= 12'h0;
               supervision_alarm[z] <= 1'b0;
            end else if (tick_100ms) begin
               sup_reg <= sup_next;
               // Alarm follows the updated time, so it rises on the tick that reaches the limit
               supervision_alarm[z] <= (sup_next >= sup_dur_lim);
            end
         end
      end
   endgenerate
endmodule : fzas_top

// >>> fzas_checker.sv
/* Port checker for fzas_top. Assumes a bind from the bench, one clock and TICK_CYCLES of 10. */
`timescale 1ns/10ps
module fzas_checker #(
   parameter int ZONES = 2,
   parameter int TICK_CYCLES = 10
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Watched ports
   input wire logic sample_valid,
   input wire logic [ZONES*12-1:0] sample_mag,
   input wire logic [ZONES*2-1:0] rx_gain,
   input wire fzas_pkg::fzas_det_cfg_s det_cfg,
   input wire fzas_pkg::fzas_sup_cfg_s sup_cfg,
   input wire logic [ZONES-1:0] intrusion_alarm,
   input wire logic [ZONES-1:0] supervision_alarm,
   input wire logic tick_100ms
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic [11:0] nt_reg;
   logic [1:0] over;
   // Gained level above threshold; gain 0 acts as 1, capped at full scale
   function automatic logic hit(input logic [11:0] m, input logic [1:0] g, input logic [11:0] t);
      logic [13:0] a;
      a = m * ((g == 2'h0) ? 14'h0001 : {12'h000, g});
      return ((a > 14'h0FFF) ? 12'hFFF : a[11:0]) > t;
   endfunction : hit
   assign over[0] = hit(sample_mag[11:0], rx_gain[1:0], det_cfg.evt_thresh);
   assign over[1] = hit(sample_mag[23:12], rx_gain[3:2], det_cfg.evt_thresh);
   // Ticks since reset; no supervision alarm can precede enough periods
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) nt_reg <= 12'h000;
      else if (tick_100ms && nt_reg != 12'hFFF) nt_reg <= nt_reg + 12'h001;
   end
   tick_period_a: assert property (tick_100ms |=> !tick_100ms [*8] ##1 !tick_100ms ##1 tick_100ms)
      else $error("tick spacing wrong");
   tick_start_a: assert property ($rose(resetn) |-> !tick_100ms [*8]) else $error("tick too early");
   sup_on_tick_a: assert property (!$stable(supervision_alarm) |-> $past(tick_100ms))
      else $error("supervision alarm moved off tick");
   sup_zero_dur_a: assert property (tick_100ms && sup_cfg.sup_dur_ticks == 12'h000 |=> &supervision_alarm)
      else $error("zero duration gave no alarm");
   sup_min_time_a: assert property ($rose(supervision_alarm[0]) |-> nt_reg >= sup_cfg.sup_dur_ticks)
      else $error("supervision alarm too soon");
   intr_cause_a: assert property ($rose(intrusion_alarm[0]) |-> $past(tick_100ms) ||
      $past(sample_valid && over[0]) || $past(sample_valid && over[0], 2)) else $error("zone 0 alarm uncaused");
   intr_zone_a: assert property ($rose(intrusion_alarm[1]) |-> $past(tick_100ms) ||
      $past(sample_valid && over[1]) || $past(sample_valid && over[1], 2)) else $error("zone 1 alarm uncaused");
   intr_clear_a: assert property ($fell(intrusion_alarm[0]) |-> tick_100ms || $past(tick_100ms))
      else $error("intrusion alarm cleared off tick");
   cover property ($rose(intrusion_alarm[0]));
   cover property ($rose(supervision_alarm[0]));
   cover property (tick_100ms && sup_cfg.sup_dur_ticks == 12'h000);
endmodule : fzas_checker

// >>> fzas_fe.sv
/* Optical front end model. Assumes its controls change at falling edges. */
`timescale 1ns/10ps
module fzas_fe (
   // Clock and controls
   input wire logic mclk,
   input wire logic slow,
   input wire logic noisy0,
   input wire logic [11:0] lvl0,
   // Samples
   output logic sample_valid = 1'h0,
   output logic [23:0] sample_mag = 24'h000000
);
   logic ph_reg = 1'h0;
   logic tg_reg = 1'h0;
   // Zone 1 always swings; idle cycles show the inverse so stale data never passes
   always @(negedge mclk) begin
      ph_reg <= !ph_reg;
      sample_valid <= !slow || ph_reg;
      tg_reg <= tg_reg ^ (!slow || ph_reg);
      sample_mag <= (!slow || ph_reg) ? {tg_reg ? 12'h0C8 : 12'h000,
         noisy0 ? (tg_reg ? 12'h0C8 : 12'h000) : lvl0} : ~sample_mag;
   end
endmodule : fzas_fe

// >>> fence_zone_alarm_supervision_tb.sv
/* Bench for fzas_top with the front end model. Assumes the checker is compiled first. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %0h got %0h", n, e, s); end end
module fence_zone_alarm_supervision_tb;
   typedef struct packed {logic [1:0] g; logic [11:0] a; logic [3:0] n; logic [4:0] gap; logic e;} fzas_row_s;
   logic mclk = 1'h0, resetn = 1'h0, slow = 1'h0, noisy0 = 1'h0, seen = 1'h0;
   logic [11:0] lvl0 = 12'h000;
   logic [3:0] rx_gain = 4'h5;
   fzas_pkg::fzas_det_cfg_s det_cfg = {8'h04, 12'h032, 16'h0005, 16'h0003, 16'h001E};
   fzas_pkg::fzas_sup_cfg_s sup_cfg = {12'h032, 12'h003};
   logic sample_valid, tick_100ms;
   logic [23:0] sample_mag;
   logic [1:0] intrusion_alarm, supervision_alarm;
   int n_mismatch = 0, num_checks = 0;
   // Gain, level, pulses, gap, alarm expected
   fzas_row_s rows [8] = '{{2'h1, 12'h03C, 4'h4, 5'h02, 1'h1}, {2'h1, 12'h03C, 4'h3, 5'h02, 1'h0},
      {2'h1, 12'h03C, 4'h1, 5'h02, 1'h0}, {2'h2, 12'h028, 4'h4, 5'h02, 1'h1},
      {2'h3, 12'h014, 4'h4, 5'h02, 1'h1}, {2'h0, 12'h02D, 4'h4, 5'h02, 1'h0},
      {2'h1, 12'h032, 4'h4, 5'h02, 1'h0}, {2'h1, 12'h03C, 4'h4, 5'h16, 1'h1}};
   always #20 mclk = !mclk;
   fzas_fe fe (.mclk(mclk), .slow(slow), .noisy0(noisy0), .lvl0(lvl0), .sample_valid(sample_valid),
      .sample_mag(sample_mag));
   fzas_top #(.ZONES(2), .TICK_CYCLES(10)) dut (.mclk(mclk), .resetn(resetn), .sample_valid(sample_valid),
      .sample_mag(sample_mag), .rx_gain(rx_gain), .det_cfg(det_cfg), .sup_cfg(sup_cfg),
      .intrusion_alarm(intrusion_alarm), .supervision_alarm(supervision_alarm), .tick_100ms(tick_100ms));
   // Falling-edge waits that latch any zone 0 intrusion alarm
   task automatic step(input int n);
      repeat (n) begin
         @(negedge mclk);
         seen = seen | intrusion_alarm[0];
      end
   endtask : step
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // Hang guard, about three times the expected run
   initial begin
      #200000;
      n_mismatch++;
      final_report;
   end
   // Rows leave 160 cycles so the zone 0 window has expired before the next
   initial begin
      step(2);
      resetn <= 1'h1;
      foreach (rows[i]) begin
         rx_gain <= {2'h1, rows[i].g};
         seen = 1'h0;
         repeat (rows[i].n) begin
            lvl0 <= rows[i].a;
            step(2);
            lvl0 <= 12'h000;
            step(rows[i].gap);
         end
         step(4);
         `CHK("row alarm", rows[i].e, seen)
         step(160);
      end
      det_cfg.dur_ticks <= 16'h0003;
      det_cfg.evt_count <= 8'h0A;
      rx_gain <= 4'h5;
      seen = 1'h0;
      lvl0 <= 12'h03C;
      step(60);
      lvl0 <= 12'h000;
      `CHK("climb alarm", 1'h1, seen)
      resetn <= 1'h0;
      step(2);
      `CHK("reset outputs", 5'h00, {intrusion_alarm, supervision_alarm, tick_100ms})
      resetn <= 1'h1;
      slow <= 1'h1;
      step(20);
      noisy0 <= 1'h1;
      step(30);
      noisy0 <= 1'h0;
      step(30);
      `CHK("sup after drop", 2'h0, supervision_alarm)
      step(40);
      `CHK("sup raised", 2'h1, supervision_alarm)
      sup_cfg.sup_dur_ticks <= 12'h000;
      step(15);
      `CHK("sup zero", 2'h3, supervision_alarm)
      final_report;
   end
endmodule : fence_zone_alarm_supervision_tb
bind fzas_top fzas_checker #(.ZONES(ZONES), .TICK_CYCLES(TICK_CYCLES)) chk (.mclk(mclk), .resetn(resetn),
   .sample_valid(sample_valid), .sample_mag(sample_mag), .rx_gain(rx_gain), .det_cfg(det_cfg),
   .sup_cfg(sup_cfg), .intrusion_alarm(intrusion_alarm), .supervision_alarm(supervision_alarm),
   .tick_100ms(tick_100ms));
